// File: logic/uart_ctl.sv
// Two-channel half-duplex UART control, frame format and shifter with APB access.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module uart_ctl (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        lowSpeedTick,
  input  wire logic        highSpeedTick,
  input  wire logic [1:0]  rxPin,
  output logic      [1:0]  txPin,
  output logic      [1:0]  rxFrameValid,
  input  wire logic [1:0]  rxFrameReady,
  output logic      [15:0] rxFrameData
);
  typedef struct packed {
    uart_ctl_pkg::chan_t [1:0] ch;
    logic [1:0]  blk;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
    logic [1:0][1:0] fifoCnt;
    logic [1:0][15:0] fifoMem;
    logic [1:0]  rxS1;
    logic [1:0]  rxS2;
    logic [1:0]  lsS1;
    logic [1:0]  lsS2;
    logic [1:0]  hsS1;
    logic [1:0]  hsS2;
    logic [1:0]  lsPrev;
    logic [1:0]  hsPrev;
    logic [1:0]  txOut;
    logic [1:0]  frameValid;
  } state_t;

  state_t q;
  state_t d;

  // Address decode shared by read and write paths.
  function automatic logic [3:0] decode(input logic [15:0] a);
    unique case (a)
      uart_ctl_pkg::CH0_BUF_OFS:  decode = 4'h1;
      uart_ctl_pkg::CH0_CON_OFS:  decode = 4'h2;
      uart_ctl_pkg::CH0_MOD0_OFS: decode = 4'h3;
      uart_ctl_pkg::CH0_MOD1_OFS: decode = 4'h4;
      uart_ctl_pkg::CH0_BRT_OFS:  decode = 4'h5;
      uart_ctl_pkg::CH1_BUF_OFS:  decode = 4'h9;
      uart_ctl_pkg::CH1_CON_OFS:  decode = 4'ha;
      uart_ctl_pkg::CH1_MOD0_OFS: decode = 4'hb;
      uart_ctl_pkg::CH1_MOD1_OFS: decode = 4'hc;
      uart_ctl_pkg::CH1_BRT_OFS:  decode = 4'hd;
      uart_ctl_pkg::BLK_OFS:      decode = 4'hf;
      default:                    decode = 4'h0;
    endcase
  endfunction

  // Data bits per character: 8, 7, 6 or 5.
  function automatic logic [2:0] lastBit(input logic [1:0] len);
    lastBit = 3'h7 - {1'b0, len};
  endfunction

  logic       access;
  logic [3:0] sel;
  always_comb begin
    access = psel && penable && !q.ready;
    sel    = decode(paddr);
  end

  always_comb begin
    d = q;
    d.ready = access;
    d.err   = access && (sel == 4'h0);
    d.rxS1  = rxPin;
    d.rxS2  = q.rxS1;
    d.lsS1  = {2{lowSpeedTick}};
    d.lsS2  = q.lsS1;
    d.hsS1  = {2{highSpeedTick}};
    d.hsS2  = q.hsS1;
    d.lsPrev = q.lsS2;
    d.hsPrev = q.hsS2;
    d.rdata = 32'h0000_0000;
    if (access) begin
      unique case (sel[2:0])
        3'h1: d.rdata[7:0] = q.ch[sel[3]].buffer;
        3'h2: d.rdata[7:0] = q.ch[sel[3]].con;
        3'h3: d.rdata[7:0] = q.ch[sel[3]].mod0;
        3'h4: d.rdata[7:0] = q.ch[sel[3]].mod1;
        3'h5: d.rdata[11:0] = q.ch[sel[3]].brt;
        3'h7: d.rdata[1:0] = q.blk;
        default: d.rdata = 32'h0000_0000;
      endcase
    end
    if (access && pwrite && sel == 4'hf) begin
      d.blk = pwdata[1:0];
    end
    for (int c = 0; c < 2; c++) begin
      logic tick;
      logic [11:0] half;
      logic sampleHit;
      logic bitEnd;
      logic inBit;
      logic outBit;
      logic popped;
      tick = q.ch[c].mod0[uart_ctl_pkg::MOD0_CKHI_BIT]
             ? (q.hsS2[c] && !q.hsPrev[c]) : (q.lsS2[c] && !q.lsPrev[c]); // RQ6
      half = {1'b0, q.ch[c].brt[11:1]} - {11'h000, q.ch[c].mod0[uart_ctl_pkg::MOD0_SAMP_BIT]};
      sampleHit = tick && (q.ch[c].baudCnt == half); // RQ8
      bitEnd = tick && (q.ch[c].baudCnt == q.ch[c].brt);
      inBit  = q.rxS2[c] ^ q.ch[c].mod1[uart_ctl_pkg::MOD1_INV_BIT]; // RQ14
      outBit = q.ch[c].mod1[uart_ctl_pkg::MOD1_ORDER_BIT]
               ? q.ch[c].shifter[lastBit(q.ch[c].mod1[1:0])] : q.ch[c].shifter[0]; // RQ14
      d.ch[c].rxDone = 1'b0;
      if (tick) begin
        d.ch[c].baudCnt = bitEnd ? 12'h000 : q.ch[c].baudCnt + 12'h001;
      end
      if (access && pwrite && sel[3] == c[0]) begin
        unique case (sel[2:0])
          3'h1: if (!q.ch[c].mod0[uart_ctl_pkg::MOD0_DIR_BIT]) begin // RQ16
            d.ch[c].buffer = pwdata[7:0];
            d.ch[c].txPending = 1'b1;
          end
          3'h2: d.ch[c].con = pwdata[7:0] & uart_ctl_pkg::CON_MASK; // RQ17
          3'h3: d.ch[c].mod0 = pwdata[7:0] & uart_ctl_pkg::MOD0_MASK; // RQ5 RQ13
          3'h4: d.ch[c].mod1 = pwdata[7:0] & uart_ctl_pkg::MOD1_MASK; // RQ10
          3'h5: d.ch[c].brt = pwdata[11:0];
          default: ;
        endcase
      end
      if (!q.ch[c].con[0]) begin
        d.ch[c].phase  = uart_ctl_pkg::ST_IDLE; // RQ3
        d.ch[c].txLine = 1'b1;
      end else if (!q.ch[c].mod0[uart_ctl_pkg::MOD0_DIR_BIT]) begin
        unique case (q.ch[c].phase)
          uart_ctl_pkg::ST_IDLE: if (q.ch[c].txPending) begin // RQ1
            d.ch[c].phase = uart_ctl_pkg::ST_START;
            d.ch[c].shifter = q.ch[c].buffer;
            d.ch[c].txPending = (access && pwrite && sel == {c[0], 3'h1});
            d.ch[c].baudCnt = 12'h000;
            d.ch[c].txLine = 1'b0;
          end else if (!(access && pwrite && sel[3] == c[0]
                         && (sel[2:0] == 3'h1 || sel[2:0] == 3'h2))) begin
            // A buffer or enable write landing in this cycle wins over the self-clear.
            d.ch[c].con = 8'h00; // RQ2
          end
          uart_ctl_pkg::ST_START: if (bitEnd) begin
            d.ch[c].phase = uart_ctl_pkg::ST_DATA;
            d.ch[c].bitIdx = 3'h0;
            d.ch[c].parAcc = q.ch[c].mod1[uart_ctl_pkg::MOD1_PAR_LO]; // RQ11
            d.ch[c].txLine = outBit;
          end
          uart_ctl_pkg::ST_DATA: if (bitEnd) begin
            d.ch[c].parAcc = q.ch[c].parAcc ^ outBit;
            d.ch[c].shifter = q.ch[c].mod1[uart_ctl_pkg::MOD1_ORDER_BIT]
                              ? {q.ch[c].shifter[6:0], 1'b0} : {1'b0, q.ch[c].shifter[7:1]};
            d.ch[c].bitIdx = q.ch[c].bitIdx + 3'h1;
            if (q.ch[c].bitIdx == lastBit(q.ch[c].mod1[1:0])) begin // RQ10
              d.ch[c].phase = q.ch[c].mod1[uart_ctl_pkg::MOD1_PAR_HI]
                              ? uart_ctl_pkg::ST_STOP : uart_ctl_pkg::ST_PARITY;
              d.ch[c].stopIdx = 1'b0;
              d.ch[c].txLine = q.ch[c].mod1[uart_ctl_pkg::MOD1_PAR_HI]
                               ? 1'b1 : q.ch[c].parAcc ^ outBit;
            end else begin
              d.ch[c].txLine = q.ch[c].mod1[uart_ctl_pkg::MOD1_ORDER_BIT]
                               ? q.ch[c].shifter[lastBit(q.ch[c].mod1[1:0]) - 3'h1]
                               : q.ch[c].shifter[1];
            end
          end
          uart_ctl_pkg::ST_PARITY: if (bitEnd) begin
            d.ch[c].phase = uart_ctl_pkg::ST_STOP;
            d.ch[c].txLine = 1'b1;
          end
          uart_ctl_pkg::ST_STOP: if (bitEnd) begin
            d.ch[c].stopIdx = 1'b1;
            if (q.ch[c].stopIdx || !q.ch[c].mod1[uart_ctl_pkg::MOD1_STOP_BIT]) begin // RQ12
              d.ch[c].phase = uart_ctl_pkg::ST_IDLE;
            end
          end
          default: d.ch[c].phase = uart_ctl_pkg::ST_IDLE;
        endcase
      end else begin
        // Receive runs until software drops the enable.
        unique case (q.ch[c].phase) // RQ4
          uart_ctl_pkg::ST_IDLE: if (!inBit) begin
            d.ch[c].phase = uart_ctl_pkg::ST_START;
            d.ch[c].baudCnt = 12'h000;
          end
          uart_ctl_pkg::ST_START: if (sampleHit) begin
            d.ch[c].phase = inBit ? uart_ctl_pkg::ST_IDLE : uart_ctl_pkg::ST_DATA;
            d.ch[c].bitIdx = 3'h0;
            d.ch[c].shifter = 8'h00;
          end
          uart_ctl_pkg::ST_DATA: if (sampleHit) begin
            d.ch[c].shifter[q.ch[c].mod1[uart_ctl_pkg::MOD1_ORDER_BIT]
                            ? lastBit(q.ch[c].mod1[1:0]) - q.ch[c].bitIdx
                            : q.ch[c].bitIdx] = inBit;
            d.ch[c].bitIdx = q.ch[c].bitIdx + 3'h1;
            if (q.ch[c].bitIdx == lastBit(q.ch[c].mod1[1:0])) begin
              d.ch[c].phase = q.ch[c].mod1[uart_ctl_pkg::MOD1_PAR_HI]
                              ? uart_ctl_pkg::ST_STOP : uart_ctl_pkg::ST_PARITY;
            end
          end
          uart_ctl_pkg::ST_PARITY: if (sampleHit) begin
            d.ch[c].phase = uart_ctl_pkg::ST_STOP;
          end
          uart_ctl_pkg::ST_STOP: if (sampleHit) begin
            d.ch[c].phase = uart_ctl_pkg::ST_IDLE;
            d.ch[c].buffer = q.ch[c].shifter; // RQ16
            d.ch[c].rxDone = 1'b1;
          end
          default: d.ch[c].phase = uart_ctl_pkg::ST_IDLE;
        endcase
      end
      // Two-entry buffer toward the receive consumer; a full buffer drops nothing already held.
      popped = q.fifoCnt[c] != 2'h0 && rxFrameReady[c];
      if (popped) begin
        d.fifoMem[c] = {8'h00, q.fifoMem[c][15:8]};
      end
      d.fifoCnt[c] = q.fifoCnt[c] - {1'b0, popped};
      if (q.ch[c].rxDone && d.fifoCnt[c] != 2'h2) begin
        d.fifoMem[c][d.fifoCnt[c][0]*8 +: 8] = q.ch[c].buffer;
        d.fifoCnt[c] = d.fifoCnt[c] + 2'h1;
      end
      if (q.blk[c]) begin
        // A disabled channel is held in its reset state.
        d.ch[c] = '0; // RQ15
        d.ch[c].brt = uart_ctl_pkg::BRT_RESET;
        d.ch[c].txLine = 1'b1;
        d.fifoCnt[c] = 2'h0;
      end
      // Pins come from flops, so a polarity change cannot glitch the line combinationally.
      d.txOut[c] = d.ch[c].txLine ^ d.ch[c].mod1[uart_ctl_pkg::MOD1_INV_BIT]; // RQ14
      d.frameValid[c] = d.fifoCnt[c] != 2'h0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '0;
      q.ch[0].brt <= uart_ctl_pkg::BRT_RESET;
      q.ch[1].brt <= uart_ctl_pkg::BRT_RESET;
      q.ch[0].txLine <= 1'b1;
      q.ch[1].txLine <= 1'b1;
      q.txOut <= 2'h3;
      q.blk <= uart_ctl_pkg::BLK_RESET;
    end else begin
      q <= d;
    end
  end

  always_comb begin
    prdata  = q.rdata;
    pready  = q.ready;
    pslverr = q.err;
    for (int c = 0; c < 2; c++) begin
      txPin[c] = q.txOut[c];
      rxFrameValid[c] = q.frameValid[c];
      rxFrameData[c*8 +: 8] = q.fifoMem[c][7:0];
    end
  end

  AST_ENABLE_DROPS: assert property (@(posedge clk) disable iff (reset) // RQ2
    (q.ch[0].con[0] && !q.ch[0].mod0[0] && q.ch[0].phase == uart_ctl_pkg::ST_IDLE
     && !q.ch[0].txPending && !q.blk[0] && !(access && pwrite)) |=> !q.ch[0].con[0])
    else $error("enable not cleared after last frame");
  AST_STOP_ABORTS: assert property (@(posedge clk) disable iff (reset) // RQ3
    !q.ch[0].con[0] |=> q.ch[0].phase == uart_ctl_pkg::ST_IDLE)
    else $error("transfer not aborted on stop");
  AST_BLOCK_RESET: assert property (@(posedge clk) disable iff (reset) // RQ15
    q.blk[0] |=> (q.ch[0].con == 8'h00 && q.ch[0].mod1 == 8'h00))
    else $error("disabled channel not reset");
  AST_UNUSED_ZERO: assert property (@(posedge clk) disable iff (reset) // RQ17
    (q.ch[0].con[7:1] == 7'h00 && q.ch[0].mod0[7:6] == 2'h0 && !q.ch[0].mod0[3]))
    else $error("unused bits set");

  // A pending byte with the channel enabled launches the start bit on the next edge.
  sequence txArmed;
    q.ch[0].con[0] && !q.ch[0].mod0[uart_ctl_pkg::MOD0_DIR_BIT] && !q.blk[0]
      && q.ch[0].phase == uart_ctl_pkg::ST_IDLE && q.ch[0].txPending;
  endsequence
  sequence txLaunched;
    q.ch[0].phase == uart_ctl_pkg::ST_START && !q.ch[0].txLine;
  endsequence
  AST_TX_START: assert property (@(posedge clk) disable iff (reset) // RQ1
    txArmed |=> txLaunched)
    else $error("start bit not launched");

  // The first of two stop bits must not return the transmitter to idle.
  sequence firstOfTwoStops;
    q.ch[0].con[0] && !q.ch[0].mod0[uart_ctl_pkg::MOD0_DIR_BIT] && !q.blk[0]
      && q.ch[0].phase == uart_ctl_pkg::ST_STOP && !q.ch[0].stopIdx
      && q.ch[0].mod1[uart_ctl_pkg::MOD1_STOP_BIT];
  endsequence
  AST_TWO_STOPS: assert property (@(posedge clk) disable iff (reset) // RQ12
    firstOfTwoStops |=> q.ch[0].phase == uart_ctl_pkg::ST_STOP)
    else $error("second stop bit skipped");

  // Short characters leave the unused upper bits of the received byte cleared.
  AST_RX_UPPER_ZERO: assert property (@(posedge clk) disable iff (reset) // RQ16
    q.ch[1].rxDone |-> (q.ch[1].buffer >> (4'h8 - {2'b00, q.ch[1].mod1[1:0]})) == 8'h00)
    else $error("received upper bits not cleared");
endmodule
`default_nettype wire

// File: logic/uart_ctl_pkg.sv
// Package with register map, field positions, reset values and types for the two-channel UART.
//
// Overview of operation
// (RQ1) Transmit starts when data written and enabled.
// (RQ2) Enable clears itself after last frame sent.
// (RQ3) Writing enable zero aborts transfer; resets zero.
// (RQ4) Receive runs while enable stays set.
// (RQ5) Mode0 bit0 selects transmit or receive.
// (RQ6) Mode0 bits2:1 select low or high clock.
// (RQ7) Software keeps receive pin select at zero.
// (RQ8) Mode0 bit5 moves sample point back one.
// (RQ9) Software writes mode0 only while stopped.
// (RQ10) Mode1 bits1:0 select eight to five bits.
// (RQ11) Mode1 bits3:2 select even, odd, none parity.
// (RQ12) Mode1 bit4 selects one or two stops.
// (RQ13) Second channel has identical control and mode0.
// (RQ14) Mode1 bits5,6 select polarity and bit order.
// (RQ15) Block disable holds channel in reset.
// (RQ16) Receive overwrites buffer, zero upper bits.
// (RQ17) Unused register bits read zero, ignore writes.
// (RQ18) Software writes mode1 only while stopped.
package uart_ctl_pkg;
  localparam logic [15:0] CH0_BUF_OFS  = 16'hf290;
  localparam logic [15:0] CH0_CON_OFS  = 16'hf291;
  localparam logic [15:0] CH0_MOD0_OFS = 16'hf292;
  localparam logic [15:0] CH0_MOD1_OFS = 16'hf293;
  localparam logic [15:0] CH0_BRT_OFS  = 16'hf294;
  localparam logic [15:0] CH1_BUF_OFS  = 16'hf298;
  localparam logic [15:0] CH1_CON_OFS  = 16'hf299;
  localparam logic [15:0] CH1_MOD0_OFS = 16'hf29a;
  localparam logic [15:0] CH1_MOD1_OFS = 16'hf29b;
  localparam logic [15:0] CH1_BRT_OFS  = 16'hf29c;
  localparam logic [15:0] BLK_OFS      = 16'hf2a0;
  localparam logic [7:0]  CON_MASK     = 8'h01;
  localparam logic [7:0]  MOD0_MASK    = 8'h37;
  localparam logic [7:0]  MOD1_MASK    = 8'h7f;
  localparam logic [7:0]  REG_RESET    = 8'h00;
  localparam logic [11:0] BRT_RESET    = 12'hfff;
  localparam logic [1:0]  BLK_RESET    = 2'h0;
  localparam int MOD0_DIR_BIT   = 0;
  localparam int MOD0_CKHI_BIT  = 2;
  localparam int MOD0_CKLO_BIT  = 1;
  localparam int MOD0_SAMP_BIT  = 5;
  localparam int MOD1_PAR_HI    = 3;
  localparam int MOD1_PAR_LO    = 2;
  localparam int MOD1_STOP_BIT  = 4;
  localparam int MOD1_INV_BIT   = 5;
  localparam int MOD1_ORDER_BIT = 6;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_START  = 3'b001,
    ST_DATA   = 3'b010,
    ST_PARITY = 3'b011,
    ST_STOP   = 3'b100
  } phase_t;

  typedef struct packed {
    logic [7:0]  con;
    logic [7:0]  mod0;
    logic [7:0]  mod1;
    logic [11:0] brt;
    logic [7:0]  buffer;
    logic        txPending;
    phase_t      phase;
    logic [11:0] baudCnt;
    logic [2:0]  bitIdx;
    logic        stopIdx;
    logic [7:0]  shifter;
    logic        parAcc;
    logic        txLine;
    logic        rxDone;
  } chan_t;

  typedef struct packed {
    logic        lowSpeedTick;
    logic        highSpeedTick;
    logic        rxLine;
  } chan_in_t;
endpackage

// File: verif/uart_control_mode_regs_tb.sv
// Self-checking bench for the two-channel serial control block.
`timescale 1ns/1ps
`default_nettype none
module uart_control_mode_regs_tb;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        lowSpeedTick = 1'b0;
  logic        highSpeedTick = 1'b0;
  logic        lowRun = 1'b1;
  logic [1:0]  ph = 2'h0;
  logic [1:0]  rxPin;
  logic [1:0]  txPin;
  logic [1:0]  rxFrameValid;
  logic [1:0]  rxFrameReady = 2'h0;
  logic [15:0] rxFrameData;
  int          n_mismatch = 0;
  int          checks_done = 0;

  uart_ctl uart_ctl_i (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lowSpeedTick(lowSpeedTick), .highSpeedTick(highSpeedTick),
    .rxPin(rxPin), .txPin(txPin), .rxFrameValid(rxFrameValid),
    .rxFrameReady(rxFrameReady), .rxFrameData(rxFrameData));
  uart_remote_model uart_remote_model_i (.txLine(txPin), .rxLine(rxPin));

  always #2.5 clk = ~clk;
  // The low-speed source can be stopped so that a wrong clock choice hangs the frame.
  always @(posedge clk) begin
    ph <= ph + 2'h1;
    highSpeedTick <= ph[1];
    lowSpeedTick <= ph[1] & lowRun;
  end

  task automatic conclude();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // The answer is looked at mid-cycle, where it is settled; pready and prdata drop again at the next edge.
    do begin
      @(negedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    @(posedge clk);
    chk(32'(n < 20), 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(rd, exp);
  endtask

  task automatic t_regs();
    logic [31:0] rd;
    logic        err;
    rdchk(uart_ctl_pkg::CH0_CON_OFS, 32'h0);
    rdchk(uart_ctl_pkg::CH0_MOD0_OFS, 32'h0);
    rdchk(uart_ctl_pkg::CH0_MOD1_OFS, 32'h0);
    rdchk(uart_ctl_pkg::CH1_CON_OFS, 32'h0);
    wr(uart_ctl_pkg::CH0_MOD0_OFS, 32'hffffffef);
    rdchk(uart_ctl_pkg::CH0_MOD0_OFS, 32'h27);
    wr(uart_ctl_pkg::CH1_MOD0_OFS, 32'hef);
    rdchk(uart_ctl_pkg::CH1_MOD0_OFS, 32'h27);
    wr(uart_ctl_pkg::CH0_MOD1_OFS, 32'hff);
    rdchk(uart_ctl_pkg::CH0_MOD1_OFS, 32'h7f);
    wr(uart_ctl_pkg::CH0_CON_OFS, 32'hfe);
    rdchk(uart_ctl_pkg::CH0_CON_OFS, 32'h0);
    apb(1'b0, 16'hf2b0, 32'h0, rd, err);
    chk({rd[30:0], err}, 32'h1);
    wr(uart_ctl_pkg::CH0_BRT_OFS, 32'h7);
  endtask

  task automatic t_tx(input logic [7:0] m0, input logic [7:0] m1, input logic [7:0] d,
                      input int nb, input logic par, input logic odd, input logic msb);
    logic [7:0]  got;
    logic [7:0]  msk;
    logic        p;
    logic [31:0] rd;
    logic        err;
    int          n;
    msk = 8'((9'h1 << nb) - 9'h1);
    n = 0;
    wr(uart_ctl_pkg::CH0_MOD0_OFS, 32'(m0));
    wr(uart_ctl_pkg::CH0_MOD1_OFS, 32'(m1));
    wr(uart_ctl_pkg::CH0_BUF_OFS, 32'(d));
    wr(uart_ctl_pkg::CH0_CON_OFS, 32'h1);
    uart_remote_model_i.recv(0, nb, par, msb, m1[5], got, p);
    chk(32'(got & msk), 32'(d & msk));
    if (par)
      chk(32'(p), 32'(^(d & msk) ^ odd));
    do begin
      apb(1'b0, uart_ctl_pkg::CH0_CON_OFS, 32'h0, rd, err);
      n++;
    end while (rd !== 32'h0 && n < 60);
    chk(rd, 32'h0);
  endtask

  task automatic t_abort();
    logic bad;
    bad = 1'b0;
    wr(uart_ctl_pkg::CH0_MOD1_OFS, 32'h0);
    wr(uart_ctl_pkg::CH0_BUF_OFS, 32'h0);
    wr(uart_ctl_pkg::CH0_CON_OFS, 32'h1);
    repeat (80) @(posedge clk);
    chk(32'(txPin[0]), 32'h0);
    wr(uart_ctl_pkg::CH0_CON_OFS, 32'h0);
    repeat (4) @(posedge clk);
    repeat (120) begin
      @(posedge clk);
      bad = bad | (txPin[0] !== 1'b1);
    end
    chk(32'(bad), 32'h0);
    rdchk(uart_ctl_pkg::CH0_CON_OFS, 32'h0);
  endtask

  task automatic t_rx();
    wr(uart_ctl_pkg::CH1_BRT_OFS, 32'h7);
    wr(uart_ctl_pkg::CH1_MOD0_OFS, 32'h21);
    wr(uart_ctl_pkg::CH1_MOD1_OFS, 32'h1);
    wr(uart_ctl_pkg::CH1_CON_OFS, 32'h1);
    uart_remote_model_i.send(1, 8'hda, 7, 1'b1);
    uart_remote_model_i.send(1, 8'h33, 7, 1'b1);
    repeat (40) @(posedge clk);
    chk({rxFrameData[15:8], 7'h0, rxFrameValid[1]}, 32'h5a01);
    rdchk(uart_ctl_pkg::CH1_BUF_OFS, 32'h33);
    wr(uart_ctl_pkg::CH1_BUF_OFS, 32'hff);
    rdchk(uart_ctl_pkg::CH1_BUF_OFS, 32'h33);
    rdchk(uart_ctl_pkg::CH1_CON_OFS, 32'h1);
    rxFrameReady <= 2'h3;
    @(posedge clk);
    #1 chk({rxFrameData[15:8], 7'h0, rxFrameValid[1]}, 32'h3301);
    @(posedge clk);
    #1 chk(32'(rxFrameValid[1]), 32'h0);
    wr(uart_ctl_pkg::CH1_CON_OFS, 32'h0);
  endtask

  task automatic t_blk();
    wr(uart_ctl_pkg::CH0_MOD1_OFS, 32'h15);
    wr(uart_ctl_pkg::BLK_OFS, 32'h1);
    rdchk(uart_ctl_pkg::CH0_MOD1_OFS, 32'h0);
    rdchk(uart_ctl_pkg::CH1_MOD1_OFS, 32'h1);
    wr(uart_ctl_pkg::BLK_OFS, 32'h0);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_tx(8'h00, 8'h00, 8'ha5, 8, 1'b1, 1'b0, 1'b0);
    lowRun <= 1'b0;
    t_tx(8'h04, 8'h77, 8'h16, 5, 1'b1, 1'b1, 1'b1);
    t_tx(8'h06, 8'h0a, 8'h2b, 6, 1'b0, 1'b0, 1'b0);
    lowRun <= 1'b1;
    t_abort();
    t_rx();
    t_blk();
    conclude();
  end

  // Guards against a hang in any wait on the line or the bus.
  initial begin
    #300us;
    n_mismatch++;
    conclude();
  end
endmodule
`default_nettype wire

// File: verif/uart_remote_model.sv
// Behavioural remote serial transceiver facing both channels' line pins.
`timescale 1ns/1ps
`default_nettype none
module uart_remote_model #(
  parameter realtime BIT_NS = 160.0
) (
  input  wire logic [1:0] txLine,
  output logic      [1:0] rxLine
);
  initial rxLine = 2'h3;

  // Sends a positive-logic frame, least significant bit first, with one stop bit.
  task automatic send(input int ch, input logic [7:0] d, input int nb, input logic par);
    logic p;
    p = ^(d & 8'((9'h1 << nb) - 9'h1));
    rxLine[ch] = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < nb; i++) begin
      rxLine[ch] = d[i];
      #(BIT_NS);
    end
    if (par) begin
      rxLine[ch] = p;
      #(BIT_NS);
    end
    rxLine[ch] = 1'b1;
    #(BIT_NS);
  endtask

  // Sampling mid-bit tolerates the synchroniser delay of the sender.
  task automatic recv(input int ch, input int nb, input logic par, input logic msb,
                      input logic inv, output logic [7:0] d, output logic p);
    logic b;
    d = 8'h00;
    p = 1'b0;
    wait (txLine[ch] === inv);
    #(BIT_NS * 1.5);
    for (int i = 0; i < nb; i++) begin
      b = txLine[ch] ^ inv;
      if (msb)
        d = {d[6:0], b};
      else
        d[i] = b;
      #(BIT_NS);
    end
    if (par)
      p = txLine[ch] ^ inv;
  endtask
endmodule
`default_nettype wire
